// File: core/amp_pkg.sv
// Package of constants for the axis motion-profile control block.
package amp_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ = 250000000;
    localparam int unsigned LIN_UNIT_MS = 20;
    localparam int unsigned BELL_UNIT_MS = 10;
    localparam int unsigned LIN_UNIT_CYC = CLK_HZ / 1000 * LIN_UNIT_MS;
    localparam int unsigned BELL_UNIT_CYC = CLK_HZ / 1000 * BELL_UNIT_MS;

    // ------------------------------------------------------------
    // Axes and widths
    // ------------------------------------------------------------
    localparam int unsigned NUM_AXES = 4;
    localparam int unsigned FEED_W = 16;
    localparam int unsigned ERR_W = 24;
    localparam int unsigned OUT_W = 40;

    // ------------------------------------------------------------
    // Fixed values
    // ------------------------------------------------------------
    localparam logic [15:0] DEFAULT_SECOND_FEED = 16'h0064;
    localparam logic [6:0] MAX_SUBROUTINE = 7'h63;
    localparam logic [13:0] MAX_APPROACH_FEED = 14'h270f;
    localparam logic [23:0] REF_COORD_MAX = 24'h7fffff;
    localparam int unsigned FF_DIV = 6;
    localparam int unsigned BELL_FF_SHIFT = 3;
    localparam int unsigned GAIN_UNITY = 64;
    localparam int unsigned GAIN_UV_PER_UNIT = 2500;

    // ------------------------------------------------------------
    // Move kinds, home states and ramp states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MOVE_RAPID = 2'b00,
        MOVE_LINEAR = 2'b01,
        MOVE_ARC = 2'b10,
        MOVE_HOME = 2'b11
    } amp_move_t;

    typedef enum logic [2:0] {
        HS_IDLE = 3'b000,
        HS_SUB = 3'b001,
        HS_FAST = 3'b010,
        HS_SLOW = 3'b011,
        HS_DONE = 3'b100
    } amp_home_t;

    typedef enum logic [1:0] {
        RP_IDLE = 2'b00,
        RP_ACC = 2'b01,
        RP_RUN = 2'b10,
        RP_DEC = 2'b11
    } amp_ramp_t;

endpackage

// File: core/amp_axis_motion_profile_control.sv
// Motion-profile control: home search, ramps, feed-forward gain and approach.
`timescale 1ns/10ps
// Notes on behaviour
// - Home search runs at first feed until switch, then second feed until marker.
// - A zero second home feed is replaced by a fixed 100 mm/min.
// - Both home feeds accept any value from 1 to 65535 per minute.
// - Running a program before required homing raises an error.
// - With end-after-homing set, a home block issues a program end.
// - A home block calls the configured subroutine 1 to 99; zero calls none.
// - Signed reference coordinate within 8388607 microns is loaded at the marker.
// - Linear ramp time is setting times 20 ms; zero disables it.
// - Linear ramp reaches positioning feed; deceleration equals acceleration.
// - Multi-axis linear or rapid moves use the longest axis ramp time.
// - Arcs get no linear ramp.
// - Linear moves ramp only at max feed unless all-linear flag is set.
// - Corner-rounding blocks are ramped only when that flag is zero.
// - Bell ramp, when enabled, applies to every move type except home, common to axes.
// - Bell ramp time is setting times 10 ms; zero means none.
// - Feed-forward Kf*F/6 is added; Kf is one eighth under bell ramps.
// - Output is K1*sum below breakpoint, else K1*Ep plus K2*(sum-Ep).
// - Per axis, approach flag enables unidirectional approach on rapid moves.
// - Approach direction flag: zero positive, one negative.
// - Approach offset is common factor times each axis backlash.
// - Final approach leg runs at the approach feed, 1 to 9999.
// - Gain 64 gives 2.5 mV per micron of following error.
// - Backlash is always in microns whatever the work units.
module amp_axis_motion_profile_control #(
    parameter int unsigned AXES = amp_pkg::NUM_AXES,
    parameter int unsigned LIN_UNIT = amp_pkg::LIN_UNIT_CYC,
    parameter int unsigned BELL_UNIT = amp_pkg::BELL_UNIT_CYC
) (
    // Clock, reset, enable
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_ce,
    // Program interpreter
    input wire logic i_run_req,
    input wire logic i_move_start,
    input wire logic [1:0] i_move_kind,
    input wire logic [AXES-1:0] i_move_axes,
    input wire logic i_corner_round,
    input wire logic i_at_max_feed,
    input wire logic [15:0] i_prog_feed,
    // Settings
    input wire logic [15:0] i_first_home_feedrate,
    input wire logic [15:0] i_second_home_feedrate,
    input wire logic i_home_required_at_powerup,
    input wire logic i_end_after_homing_flag,
    input wire logic [6:0] i_homing_subroutine_number,
    input wire logic [23:0] i_reference_point_coordinate,
    input wire logic [7:0] i_linear_ramp_time [AXES],
    input wire logic [15:0] i_positioning_feedrate,
    input wire logic i_all_linear_ramps_flag,
    input wire logic i_corner_rounding_ramp_flag,
    input wire logic i_bell_ramp_enable,
    input wire logic [7:0] i_bell_ramp_duration,
    input wire logic [7:0] i_feed_forward_setting [AXES],
    input wire logic [15:0] i_gain_breakpoint [AXES],
    input wire logic [7:0] i_first_gain [AXES],
    input wire logic [7:0] i_second_gain [AXES],
    input wire logic [2*AXES-1:0] i_approach_enable_and_direction,
    input wire logic [7:0] i_approach_distance_factor,
    input wire logic [13:0] i_approach_feedrate,
    input wire logic [7:0] i_backlash_amount [AXES],
    // Machine side
    input wire logic i_home_switch,
    input wire logic i_marker_pulse,
    input wire logic signed [23:0] i_follow_err [AXES],
    // Outputs
    output logic o_run_error,
    output logic o_homed,
    output logic o_prog_end,
    output logic o_sub_call,
    output logic [6:0] o_sub_number,
    output logic [15:0] o_home_feed,
    output logic signed [23:0] o_axis_position,
    output logic [15:0] o_feed_cmd,
    output logic signed [39:0] o_analog [AXES],
    output logic [AXES-1:0] o_approach_dir_neg,
    output logic [15:0] o_approach_offset [AXES],
    output logic [13:0] o_approach_feed
);

    // ------------------------------------------------------------
    // Home search
    // ------------------------------------------------------------
    amp_pkg::amp_home_t hs_q, hs_d;
    logic homed_q;
    wire home_start = i_move_start && (i_move_kind == amp_pkg::MOVE_HOME);
    wire sub_valid = (i_homing_subroutine_number != 7'h00) &&
        (i_homing_subroutine_number <= amp_pkg::MAX_SUBROUTINE);
    wire [15:0] second_feed = (i_second_home_feedrate == 16'h0000) ?
        amp_pkg::DEFAULT_SECOND_FEED : i_second_home_feedrate;

    always_comb begin
        hs_d = hs_q;
        case (hs_q)
            amp_pkg::HS_IDLE: if (home_start) hs_d = sub_valid ? amp_pkg::HS_SUB :
                amp_pkg::HS_FAST;
            amp_pkg::HS_SUB: hs_d = amp_pkg::HS_FAST;
            amp_pkg::HS_FAST: if (i_home_switch) hs_d = amp_pkg::HS_SLOW;
            amp_pkg::HS_SLOW: if (i_marker_pulse) hs_d = amp_pkg::HS_DONE;
            amp_pkg::HS_DONE: hs_d = amp_pkg::HS_IDLE;
            default: hs_d = amp_pkg::HS_IDLE;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            hs_q <= amp_pkg::HS_IDLE;
            homed_q <= 1'b0;
            o_homed <= 1'b0;
            o_run_error <= 1'b0;
            o_prog_end <= 1'b0;
            o_sub_call <= 1'b0;
            o_sub_number <= 7'h00;
            o_home_feed <= 16'h0000;
            o_axis_position <= 24'sh000000;
        end else if (i_ce) begin
            hs_q <= hs_d;
            if (hs_d == amp_pkg::HS_DONE) begin
                homed_q <= 1'b1;
                o_homed <= 1'b1;
                o_axis_position <= $signed(i_reference_point_coordinate);
            end
            o_run_error <= i_run_req && i_home_required_at_powerup && !homed_q;
            o_prog_end <= (hs_d == amp_pkg::HS_DONE) && i_end_after_homing_flag;
            o_sub_call <= (hs_d == amp_pkg::HS_SUB);
            o_sub_number <= i_homing_subroutine_number;
            case (hs_d)
                amp_pkg::HS_FAST: o_home_feed <= i_first_home_feedrate;
                amp_pkg::HS_SLOW: o_home_feed <= second_feed;
                default: o_home_feed <= 16'h0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Ramp selection
    // ------------------------------------------------------------
    logic [7:0] lin_max;
    always_comb begin
        lin_max = 8'h00;
        for (int a = 0; a < AXES; a++) begin
            if (i_move_axes[a] && i_linear_ramp_time[a] > lin_max) begin
                lin_max = i_linear_ramp_time[a];
            end
        end
    end

    wire is_rapid = (i_move_kind == amp_pkg::MOVE_RAPID);
    wire is_lin = (i_move_kind == amp_pkg::MOVE_LINEAR);
    wire lin_ok = (is_rapid || (is_lin && (i_all_linear_ramps_flag || i_at_max_feed)))
        && !(i_corner_round && i_corner_rounding_ramp_flag);
    wire bell_on = i_bell_ramp_enable && (i_bell_ramp_duration != 8'h00);
    wire [7:0] ramp_units = bell_on ? i_bell_ramp_duration : (lin_ok ? lin_max : 8'h00);
    wire [31:0] unit_cyc = bell_q ? 32'(BELL_UNIT) : 32'(LIN_UNIT);
    wire [15:0] target = bell_on ? i_prog_feed : i_positioning_feedrate;

    // ------------------------------------------------------------
    // Ramp generator
    // ------------------------------------------------------------
    amp_pkg::amp_ramp_t rp_q;
    logic [31:0] tick_q;
    logic [7:0] step_q, units_q;
    logic bell_q;
    logic [15:0] tgt_q;
    wire move_go = i_move_start && (i_move_kind != amp_pkg::MOVE_HOME);
    wire tick = (tick_q == unit_cyc - 32'd1);
    // S-curve: 3x^2 - 2x^3 with x = step/units, scaled by target.
    wire [15:0] x16 = (step_q >= units_q) ? 16'hffff : 16'((32'(step_q) << 16) / units_q);
    wire [31:0] x2 = (32'(x16) * 32'(x16)) >> 16;
    wire [31:0] x3 = (x2 * 32'(x16)) >> 16;
    wire [31:0] s_frac = (3 * x2 - 2 * x3);
    wire [15:0] lin_feed = 16'((32'(tgt_q) * 32'(step_q)) / ((units_q == 8'h00) ? 32'd1 :
        32'(units_q)));
    wire [15:0] bell_feed = 16'((48'(tgt_q) * 48'(s_frac[16:0])) >> 16);
    wire [15:0] ramp_feed = bell_q ? bell_feed : lin_feed;

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            rp_q <= amp_pkg::RP_IDLE;
            tick_q <= 32'd0;
            step_q <= 8'h00;
            units_q <= 8'h00;
            bell_q <= 1'b0;
            tgt_q <= 16'h0000;
            o_feed_cmd <= 16'h0000;
        end else if (i_ce) begin
            // Restarting the count in RUN gives the first deceleration step its full length.
            tick_q <= (tick || rp_q == amp_pkg::RP_IDLE || rp_q == amp_pkg::RP_RUN) ? 32'd0 :
                tick_q + 32'd1;
            case (rp_q)
                amp_pkg::RP_IDLE: if (move_go) begin
                    units_q <= ramp_units;
                    bell_q <= bell_on;
                    tgt_q <= target;
                    step_q <= 8'h00;
                    rp_q <= (ramp_units == 8'h00) ? amp_pkg::RP_RUN : amp_pkg::RP_ACC;
                end
                amp_pkg::RP_ACC: if (tick) begin
                    step_q <= step_q + 8'h01;
                    if (step_q + 8'h01 == units_q) rp_q <= amp_pkg::RP_RUN;
                end
                amp_pkg::RP_RUN: if (!i_move_axes[0] && i_move_axes == '0) begin
                    rp_q <= (units_q == 8'h00) ? amp_pkg::RP_IDLE : amp_pkg::RP_DEC;
                end
                amp_pkg::RP_DEC: if (tick) begin
                    step_q <= step_q - 8'h01;
                    if (step_q == 8'h01) rp_q <= amp_pkg::RP_IDLE;
                end
                default: rp_q <= amp_pkg::RP_IDLE;
            endcase
            case (rp_q)
                amp_pkg::RP_ACC, amp_pkg::RP_DEC: o_feed_cmd <= ramp_feed;
                amp_pkg::RP_RUN: o_feed_cmd <= tgt_q;
                default: o_feed_cmd <= 16'h0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Per-axis gain stage and approach
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < AXES; g++) begin : g_axis
            wire [7:0] kf = bell_on ? (i_feed_forward_setting[g] >> amp_pkg::BELL_FF_SHIFT) :
                i_feed_forward_setting[g];
            wire signed [39:0] ff = 40'sd0 + 40'((32'(kf) * 32'(i_prog_feed)) /
                amp_pkg::FF_DIV);
            wire signed [39:0] sum = 40'(i_follow_err[g]) + ff;
            wire signed [39:0] ep = 40'sd0 + 40'(i_gain_breakpoint[g]);
            wire signed [39:0] k1 = 40'sd0 + 40'(i_first_gain[g]);
            wire signed [39:0] k2 = 40'sd0 + 40'(i_second_gain[g]);
            // Output in gain-unit x micron; 64 units give 2.5 mV per micron.
            wire signed [39:0] analog = (sum < ep) ? k1 * sum :
                k1 * ep + k2 * (sum - ep);
            always_ff @(posedge i_clk) begin
                if (i_sys_rst) begin
                    o_analog[g] <= 40'sh0;
                    o_approach_dir_neg[g] <= 1'b0;
                    o_approach_offset[g] <= 16'h0000;
                end else if (i_ce) begin
                    o_analog[g] <= analog;
                    o_approach_dir_neg[g] <= i_approach_enable_and_direction[AXES+g];
                    o_approach_offset[g] <= (is_rapid && i_approach_enable_and_direction[g]) ?
                        16'(i_approach_distance_factor) * 16'(i_backlash_amount[g]) :
                        16'h0000;
                end
            end
        end
    endgenerate

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_approach_feed <= 14'h0001;
        end else if (i_ce) begin
            o_approach_feed <= (i_approach_feedrate == 14'h0000) ? 14'h0001 :
                ((i_approach_feedrate > amp_pkg::MAX_APPROACH_FEED) ?
                amp_pkg::MAX_APPROACH_FEED : i_approach_feedrate);
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_second_feed;
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_ce && hs_d == amp_pkg::HS_SLOW && i_second_home_feedrate == 16'h0000) |=>
        (o_home_feed == 16'h0064);
    endproperty
    a_second_feed: assert property (p_second_feed) else $error("second feed default wrong");

    property p_run_err;
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_ce && i_run_req && i_home_required_at_powerup && !homed_q) |=> o_run_error;
    endproperty
    a_run_err: assert property (p_run_err) else $error("run error missing");

    property p_m30;
        @(posedge i_clk) disable iff (i_sys_rst)
        o_prog_end |-> (i_end_after_homing_flag || $past(i_end_after_homing_flag)) && o_homed;
    endproperty
    a_m30: assert property (p_m30) else $error("program end without homing");

    property p_fast;
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_ce && hs_d == amp_pkg::HS_FAST) |=> (o_home_feed == $past(i_first_home_feedrate));
    endproperty
    a_fast: assert property (p_fast) else $error("first feed wrong");

    property p_sub;
        @(posedge i_clk) disable iff (i_sys_rst)
        o_sub_call |-> o_sub_number != 7'h00;
    endproperty
    a_sub: assert property (p_sub) else $error("subroutine zero called");

    property p_dir;
        @(posedge i_clk) disable iff (i_sys_rst)
        i_ce |=> o_approach_dir_neg[0] == $past(i_approach_enable_and_direction[AXES]);
    endproperty
    a_dir: assert property (p_dir) else $error("approach direction wrong");

    property p_afeed;
        @(posedge i_clk) disable iff (i_sys_rst)
        o_approach_feed >= 14'h0001 && o_approach_feed <= 14'h270f;
    endproperty
    a_afeed: assert property (p_afeed) else $error("approach feed out of range");

    property p_run_feed;
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_ce && rp_q == amp_pkg::RP_RUN) |=> o_feed_cmd == $past(tgt_q);
    endproperty
    a_run_feed: assert property (p_run_feed) else $error("run feed not target");

    property p_slow;
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_ce && hs_d == amp_pkg::HS_SLOW && i_second_home_feedrate != 16'h0000) |=>
        (o_home_feed == $past(i_second_home_feedrate));
    endproperty
    a_slow: assert property (p_slow) else $error("second feed not used");

    property p_no_end;
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_ce && hs_d == amp_pkg::HS_DONE && !i_end_after_homing_flag) |=> !o_prog_end;
    endproperty
    a_no_end: assert property (p_no_end) else $error("program end without flag");

    property p_ref;
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_ce && hs_d == amp_pkg::HS_DONE) |=>
        (o_homed && o_axis_position == $signed($past(i_reference_point_coordinate)));
    endproperty
    a_ref: assert property (p_ref) else $error("reference coordinate not loaded");

    property p_arc;
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_ce && rp_q == amp_pkg::RP_IDLE && move_go && i_move_kind == amp_pkg::MOVE_ARC &&
        !bell_on) |=> (rp_q == amp_pkg::RP_RUN);
    endproperty
    a_arc: assert property (p_arc) else $error("arc move was ramped");

endmodule

// File: dv/amp_axis_partner.sv
// Model of the home switch and the encoder marker seen during a home search.
`timescale 1ns/10ps
module amp_axis_partner #(
    parameter int unsigned SW_DLY = 10,
    parameter int unsigned MK_DLY = 10
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // Commanded search feed
    input wire logic [15:0] i_home_feed,
    // Machine signals
    output logic o_home_switch,
    output logic o_marker_pulse
);
    int cnt_q;
    // ------------------------------------------------------------
    // Switch closes after a stretch of travel, marker repeats per turn
    // ------------------------------------------------------------
    // The marker recurs every MK_DLY+1 cycles, so a missed one is not fatal.
    always @(posedge i_clk) begin
        o_marker_pulse <= !i_sys_rst && i_home_feed != 16'h0000 && o_home_switch &&
            cnt_q == MK_DLY;
        if (i_sys_rst || i_home_feed == 16'h0000) begin
            cnt_q <= 0;
            o_home_switch <= 1'b0;
        end else begin
            cnt_q <= cnt_q + 1;
            if (!o_home_switch && cnt_q == SW_DLY) begin
                o_home_switch <= 1'b1;
                cnt_q <= 0;
            end else if (o_home_switch && cnt_q == MK_DLY) begin
                cnt_q <= 0;
            end
        end
    end
endmodule

// File: dv/tb_top.sv
// Self-checking testbench for the axis motion-profile control block.
`timescale 1ns/10ps
module tb_top;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    typedef struct packed {logic [23:0] err; logic [15:0] ep; logic [7:0] k1; logic [7:0] k2;} amp_row_t;
    amp_row_t rows [4] = '{'{24'd100, 16'd200, 8'd64, 8'd32}, '{24'd200, 16'd200, 8'd64, 8'd32},
        '{24'd300, 16'd200, 8'd64, 8'd32}, '{24'd1000, 16'd500, 8'd10, 8'd255}};
    logic i_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic run_req = 1'b0, mv_start = 1'b0, home_req = 1'b1, end_flag = 1'b1, bell_en = 1'b0;
    logic [1:0] kind = 2'h0;
    logic ce = 1'b1, corner = 1'b0, at_max = 1'b0, all_lin = 1'b0, corner_flag = 1'b0;
    logic [3:0] axes = 4'h0;
    logic [15:0] pfeed = 16'h0006, feed1 = 16'h1000, feed2 = 16'h0000, posfeed = 16'h03e8;
    logic [6:0] sub_no = 7'h05;
    logic [23:0] ref_c = 24'h123456;
    logic [7:0] bell_dur = 8'h03, app_fac = 8'h03, app_en = 8'ha5;
    logic [13:0] app_feed = 14'h0000;
    logic [7:0] lrt [4], ffs [4], k1 [4], k2 [4], bkl [4];
    logic [15:0] ep [4], offs [4], home_feed, feed_cmd;
    logic signed [23:0] ferr [4], pos;
    logic signed [39:0] analog [4];
    logic run_err, homed, prog_end, sub_call, home_sw, marker;
    logic [6:0] sub_num, last_sub;
    logic [3:0] dir_neg;
    logic [13:0] app_out;
    int n_errors = 0, n_compared = 0, n_end = 0, n_sub = 0, cyc = 0;

    amp_axis_motion_profile_control #(.LIN_UNIT(4), .BELL_UNIT(2)) dut (
        .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce(ce), .i_run_req(run_req),
        .i_move_start(mv_start), .i_move_kind(kind), .i_move_axes(axes),
        .i_corner_round(corner), .i_at_max_feed(at_max), .i_prog_feed(pfeed),
        .i_first_home_feedrate(feed1), .i_second_home_feedrate(feed2),
        .i_home_required_at_powerup(home_req), .i_end_after_homing_flag(end_flag),
        .i_homing_subroutine_number(sub_no), .i_reference_point_coordinate(ref_c),
        .i_linear_ramp_time(lrt), .i_positioning_feedrate(posfeed),
        .i_all_linear_ramps_flag(all_lin), .i_corner_rounding_ramp_flag(corner_flag),
        .i_bell_ramp_enable(bell_en), .i_bell_ramp_duration(bell_dur),
        .i_feed_forward_setting(ffs), .i_gain_breakpoint(ep), .i_first_gain(k1),
        .i_second_gain(k2), .i_approach_enable_and_direction(app_en),
        .i_approach_distance_factor(app_fac), .i_approach_feedrate(app_feed),
        .i_backlash_amount(bkl), .i_home_switch(home_sw), .i_marker_pulse(marker),
        .i_follow_err(ferr), .o_run_error(run_err), .o_homed(homed), .o_prog_end(prog_end),
        .o_sub_call(sub_call), .o_sub_number(sub_num), .o_home_feed(home_feed),
        .o_axis_position(pos), .o_feed_cmd(feed_cmd), .o_analog(analog),
        .o_approach_dir_neg(dir_neg), .o_approach_offset(offs), .o_approach_feed(app_out));

    amp_axis_partner partner (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
        .i_home_feed(home_feed), .o_home_switch(home_sw), .o_marker_pulse(marker));

    // ------------------------------------------------------------
    // Clock, pulse counters, timeout and helpers
    // ------------------------------------------------------------
    always #2 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        cyc++;
        if (prog_end === 1'b1) n_end++;
        if (sub_call === 1'b1) begin
            n_sub++;
            last_sub = sub_num;
        end
        if (cyc == 20000) begin
            n_errors++;
            results();
        end
    end
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    function automatic logic [63:0] gain(input logic [63:0] e, p, a, b);
        return (e < p) ? a * e : a * p + b * (e - p);
    endfunction
    task automatic wait_feed(input logic [15:0] v, output int n);
        n = 0;
        while (feed_cmd !== v && n < 100) begin
            tick(1);
            n++;
        end
    endtask
    task automatic start(input logic [1:0] k, input logic [3:0] ax);
        @(posedge i_clk);
        mv_start <= 1'b1;
        kind <= k;
        axes <= ax;
        @(posedge i_clk);
        mv_start <= 1'b0;
        #1;
    endtask
    task automatic ramp(input logic [15:0] tgt, input int lo, input int hi);
        int n;
        wait_feed(tgt, n);
        chk(n >= lo && n <= hi, 1);
        @(posedge i_clk);
        axes <= 4'h0;
        #1;
        wait_feed(16'h0000, n);
        // The drop of the axes is seen one edge later than a start strobe.
        chk(n >= lo + 1 && n <= hi + 1, 1);
    endtask
    task automatic home(input logic [15:0] slow);
        int n;
        n = 0;
        start(2'h3, 4'h1);
        tick(4);
        chk(home_feed, feed1);
        while (home_sw !== 1'b1 && n < 100) begin
            tick(1);
            n++;
        end
        tick(3);
        chk(home_feed, slow);
        while (homed !== 1'b1 && n < 200) begin
            tick(1);
            n++;
        end
        chk(pos, {{40{ref_c[23]}}, ref_c});
        tick(1);
        chk(home_feed, 0);
    endtask
    task automatic results();
        $display("compared=%0d errors=%0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        lrt = '{8'h02, 8'h05, 8'h01, 8'h09};
        bkl = '{8'h0a, 8'h14, 8'h1e, 8'h28};
        ffs = '{default: 8'h00};
        k1 = '{default: 8'h00};
        k2 = '{default: 8'h00};
        ep = '{default: 16'h0000};
        ferr = '{default: 24'h000000};
        tick(9);
        chk(app_out, 1);
        chk(homed, 0);
        @(posedge i_clk);
        i_sys_rst <= 1'b0;
        run_req <= 1'b1;
        tick(3);
        chk(run_err, 1);
        run_req <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            @(posedge i_clk);
            foreach (ferr[a]) begin
                ferr[a] <= rows[i].err;
                ep[a] <= rows[i].ep;
                k1[a] <= rows[i].k1;
                k2[a] <= rows[i].k2;
            end
            tick(3);
            chk(analog[3], gain(rows[i].err, rows[i].ep, rows[i].k1, rows[i].k2));
        end
        // Feed-forward: 48 * 6 / 6 under linear ramps, one eighth of that under bell.
        ffs <= '{default: 8'h30};
        ferr <= '{default: 24'd100};
        ep <= '{default: 16'd1000};
        k1 <= '{default: 8'h01};
        tick(3);
        chk(analog[0], 148);
        bell_en <= 1'b1;
        tick(3);
        chk(analog[0], 106);
        bell_en <= 1'b0;
        chk(dir_neg, 4'ha);
        app_feed <= 14'h3fff;
        tick(3);
        chk(app_out, 14'h270f);
        ce <= 1'b0;
        app_feed <= 14'h0005;
        tick(3);
        chk(app_out, 14'h270f);
        ce <= 1'b1;
        tick(3);
        chk(app_out, 14'h0005);
        home(16'h0064);
        chk(n_sub, 1);
        chk(last_sub, 7'h05);
        chk(n_end, 1);
        run_req <= 1'b1;
        tick(3);
        chk(run_err, 0);
        run_req <= 1'b0;
        start(2'h0, 4'h7);
        ramp(16'h03e8, 17, 24);
        start(2'h0, 4'h7);
        tick(6);
        chk({offs[2], offs[1], offs[0]}, {16'd90, 16'd0, 16'd30});
        ramp(16'h03e8, 10, 24);
        pfeed <= 16'h01f4;
        bell_en <= 1'b1;
        start(2'h2, 4'h1);
        ramp(16'h01f4, 5, 7);
        bell_en <= 1'b0;
        start(2'h2, 4'h7);
        ramp(16'h03e8, 1, 1);
        start(2'h1, 4'h7);
        ramp(16'h03e8, 1, 1);
        at_max <= 1'b1;
        start(2'h1, 4'h7);
        ramp(16'h03e8, 17, 24);
        at_max <= 1'b0;
        all_lin <= 1'b1;
        start(2'h1, 4'h7);
        ramp(16'h03e8, 17, 24);
        corner <= 1'b1;
        corner_flag <= 1'b1;
        start(2'h0, 4'h7);
        ramp(16'h03e8, 1, 1);
        corner_flag <= 1'b0;
        start(2'h0, 4'h7);
        ramp(16'h03e8, 17, 24);
        @(posedge i_clk);
        i_sys_rst <= 1'b1;
        feed2 <= 16'h0200;
        sub_no <= 7'h00;
        end_flag <= 1'b0;
        tick(2);
        chk(homed, 0);
        chk(app_out, 1);
        @(posedge i_clk);
        i_sys_rst <= 1'b0;
        home(16'h0200);
        chk(n_sub, 1);
        chk(n_end, 1);
        results();
    end
endmodule
